// *** rtl/ulsd_pkg.sv ***
// Shared constants and state types for the ULPI transceiver digital core.
// Assumes one system clock, with the analog front end retimed onto it.
package ulsd_pkg;
  // ****************************************
  // Line coding
  // ****************************************
  localparam logic [7:0] SYNC_BYTE     = 8'h80;
  localparam logic [2:0] STUFF_RUN     = 3'h6;
  localparam logic [2:0] SYNC_MIN_ZERO = 3'h4;
  localparam logic [2:0] BYTE_LAST     = 3'h7;
  localparam logic [2:0] EOP_SE0_BITS  = 3'h2;
  // ****************************************
  // Link command byte
  // ****************************************
  localparam int         CMD_MSB  = 7;
  localparam int         CMD_LSB  = 6;
  localparam int         ADDR_W   = 6;
  localparam logic [1:0] CMD_TX   = 2'h1;
  localparam logic [1:0] CMD_REGW = 2'h2;
  localparam logic [1:0] CMD_REGR = 2'h3;
  // ****************************************
  // Status byte and pins
  // ****************************************
  localparam int         IRQ_W       = 4;
  localparam int         RXC_LS_LSB  = 0;
  localparam int         RXC_IRQ_LSB = 2;
  localparam int         RXC_EVT_LSB = 6;
  localparam logic [1:0] EVT_IDLE    = 2'h0;
  localparam logic [1:0] EVT_ACTIVE  = 2'h1;
  localparam logic [1:0] EVT_ERROR   = 2'h3;
  localparam logic [1:0] MODE_PAR    = 2'h0;
  localparam logic [1:0] MODE_SER6   = 2'h1;
  localparam logic [1:0] MODE_SER3   = 2'h2;
  localparam logic [IRQ_W+1:0] PIN_RST = {{IRQ_W{1'b0}}, 2'h1};

  typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_TAIL, TX_EOP} ulsd_tx_state_type;
  typedef enum logic [1:0] {RX_HUNT, RX_DATA} ulsd_rx_state_type;
  typedef enum logic [3:0] {
    C_IDLE, C_TURN_UP, C_RX, C_RXCMD, C_TURN_DN, C_TX, C_REGW, C_REGW_STP, C_RR_DATA
  } ulsd_ctl_state_type;
endpackage : ulsd_pkg

// *** rtl/ulsd_serializer.sv ***
// Transmit serializer: framing, bit stuffing and NRZI coding, one bit per enabled clock.
// Assumes the caller loads only while rdy_o is high.
module ulsd_serializer import ulsd_pkg::*; (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  input  wire logic       clr_i,
  input  wire logic       ld_i,
  input  wire logic [7:0] ld_byte_i,
  input  wire logic       ld_framed_i,
  input  wire logic       end_i,
  output logic            rdy_o,
  output logic            line_o,
  output logic            se0_o,
  output logic            en_o
);
  ulsd_tx_state_type st_q;
  logic [7:0] sh_q, hold_q;
  logic       hold_v_q, framed_q, pkt_framed_q, end_q, line_q, en_q, se0_q;
  logic [2:0] cnt_q, ones_q, ones_nx;
  logic       stuff, take, start;

  assign stuff   = ones_q == STUFF_RUN;
  assign ones_nx = sh_q[0] ? ones_q + 3'h1 : 3'h0;
  // Unframed bytes are consumed at once; framed ones wait behind the sync pattern
  assign start   = (st_q == TX_IDLE) && hold_v_q;
  assign take    = (start && !framed_q) ||
                   ((st_q == TX_DATA) && !stuff && (cnt_q == BYTE_LAST) && hold_v_q);
  assign rdy_o   = !hold_v_q && !end_q;
  assign line_o  = line_q;
  // Enables are registered to frame the line level, which lags its bit by a cycle;
  // otherwise the last payload bit would be hidden under SE0
  assign se0_o   = se0_q;
  assign en_o    = en_q;

  // ****************************************
  // Holding byte
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_v_q <= 1'b0;
      hold_q   <= 8'h00;
      framed_q <= 1'b0;
    end else if (ce_i) begin
      if (clr_i) begin
        hold_v_q <= 1'b0;
      end else if (ld_i) begin
        hold_v_q <= 1'b1;
        hold_q   <= ld_byte_i;
        framed_q <= ld_framed_i;
      end else if (take) begin
        hold_v_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bit engine
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q         <= TX_IDLE;
      sh_q         <= 8'h00;
      cnt_q        <= 3'h0;
      ones_q       <= 3'h0;
      line_q       <= 1'b1;
      pkt_framed_q <= 1'b0;
      end_q        <= 1'b0;
      en_q         <= 1'b0;
      se0_q        <= 1'b0;
    end else if (ce_i) begin
      // A late end request is kept even while the packet drains
      end_q <= !clr_i && (end_i || (end_q && !((st_q == TX_IDLE) && !hold_v_q)));
      en_q  <= !clr_i && (st_q != TX_IDLE);
      se0_q <= !clr_i && (st_q == TX_EOP) && (cnt_q < EOP_SE0_BITS);
      if (clr_i) begin
        st_q   <= TX_IDLE;
        line_q <= 1'b1;
      end else begin
        case (st_q)
          TX_IDLE: begin
            cnt_q  <= 3'h0;
            ones_q <= 3'h0;
            line_q <= 1'b1;
            if (start) begin
              sh_q         <= framed_q ? SYNC_BYTE : hold_q;
              pkt_framed_q <= framed_q;
              st_q         <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (stuff) begin
              line_q <= ~line_q;
              ones_q <= 3'h0;
            end else begin
              line_q <= sh_q[0] ? line_q : ~line_q;
              ones_q <= ones_nx;
              sh_q   <= {1'b0, sh_q[7:1]};
              cnt_q  <= cnt_q + 3'h1;
              if (cnt_q == BYTE_LAST) begin
                if (hold_v_q) begin
                  sh_q <= hold_q;
                end else if (ones_nx == STUFF_RUN) begin
                  st_q <= TX_TAIL;
                end else begin
                  st_q <= pkt_framed_q ? TX_EOP : TX_IDLE;
                end
              end
            end
          end
          TX_TAIL: begin
            // Last byte ended on a run of ones; its stuff bit precedes the end
            line_q <= ~line_q;
            ones_q <= 3'h0;
            cnt_q  <= 3'h0;
            st_q   <= pkt_framed_q ? TX_EOP : TX_IDLE;
          end
          TX_EOP: begin
            line_q <= 1'b1;
            cnt_q  <= cnt_q + 3'h1;
            if (cnt_q == EOP_SE0_BITS) begin
              st_q <= TX_IDLE;
            end
          end
          default: st_q <= TX_IDLE;
        endcase
      end
    end
  end
endmodule : ulsd_serializer

// *** rtl/ulsd_ulpi_phy.sv ***
// ULPI interface controller with receive deserializer, for a USB transceiver core.
// Assumes the link shares sys_clk_i; line inputs come retimed from the clock recovery.
module ulsd_ulpi_phy import ulsd_pkg::*; (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  input  wire logic             chip_select_powerdown_n_i,
  input  wire logic             vio_present_i,
  input  wire logic [1:0]       serial_mode_i,
  input  wire logic             bus_pulldown_en_i,
  input  wire logic [7:0]       ulpi_data_i,
  output logic      [7:0]       ulpi_data_o,
  output logic      [7:0]       ulpi_data_oe_n_o,
  output logic                  ulpi_dir_o,
  output logic                  ulpi_nxt_o,
  input  wire logic             ulpi_stp_i,
  output logic                  ulpi_float_o,
  output logic                  ulpi_pulldown_o,
  input  wire logic             line_rx_i,
  input  wire logic             line_rx_se0_i,
  input  wire logic             line_rx_active_i,
  output logic                  line_tx_o,
  output logic                  line_tx_se0_o,
  output logic                  line_tx_en_o,
  input  wire logic [IRQ_W-1:0] irq_src_i,
  input  wire logic [IRQ_W-1:0] irq_en_i,
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic      [7:0]       reg_wdata_o,
  output logic                  reg_we_o,
  output logic                  reg_re_o,
  input  wire logic [7:0]       reg_rdata_i,
  output logic                  regulator_off_o,
  output logic                  powerdown_o
);
  function automatic logic [1:0] cmd_kind(input logic [7:0] b);
    cmd_kind = b[CMD_MSB:CMD_LSB];
  endfunction : cmd_kind

  localparam int NSYNC = IRQ_W + 2;
  logic [NSYNC-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, agree;
  logic pd_mode, serial, clr;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign agree = ~(pin_s2_q ^ pin_s3_q);
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      pin_s3_q <= PIN_RST;
      pin_q    <= PIN_RST;
    end else if (ce_i) begin
      pin_s1_q <= {irq_src_i, vio_present_i, chip_select_powerdown_n_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= (pin_q & ~agree) | (pin_s3_q & agree);
    end
  end

  assign pd_mode         = pin_q[0] || !pin_q[1];
  assign regulator_off_o = pd_mode;
  assign powerdown_o     = pd_mode;
  assign ulpi_float_o    = pin_q[0];
  assign ulpi_pulldown_o = bus_pulldown_en_i && !pin_q[0];
  assign serial          = serial_mode_i != MODE_PAR;
  assign clr             = pd_mode || serial;

  // ****************************************
  // Receive deserializer
  // ****************************************
  ulsd_rx_state_type rx_st_q;
  logic [7:0] rx_sh_q, rx_byte_q;
  logic [2:0] rx_cnt_q, rx_ones_q, rx_zero_q;
  logic       rx_prev_q, rx_dec, rx_byte_v_q, rx_pkt_q, rx_err_q, rx_take;
  logic       err_set, err_clr, byte_set;

  assign rx_dec = line_rx_i == rx_prev_q;
  always_comb begin
    err_set  = 1'b0;
    err_clr  = 1'b0;
    byte_set = 1'b0;
    if (!clr && rx_st_q == RX_HUNT) begin
      err_clr = line_rx_active_i && rx_dec && (rx_zero_q >= SYNC_MIN_ZERO);
    end else if (!clr) begin
      if (!line_rx_active_i) begin
        err_set = 1'b1;
      end else if (line_rx_se0_i) begin
        err_set = rx_cnt_q != 3'h0;
      end else if (rx_ones_q == STUFF_RUN) begin
        err_set = rx_dec;
      end else if (rx_cnt_q == BYTE_LAST) begin
        byte_set = 1'b1;
        err_set  = rx_byte_v_q && !rx_take;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st_q     <= RX_HUNT;
      rx_sh_q     <= 8'h00;
      rx_byte_q   <= 8'h00;
      rx_cnt_q    <= 3'h0;
      rx_ones_q   <= 3'h0;
      rx_zero_q   <= 3'h0;
      rx_prev_q   <= 1'b1;
      rx_byte_v_q <= 1'b0;
      rx_pkt_q    <= 1'b0;
      rx_err_q    <= 1'b0;
    end else if (ce_i) begin
      rx_prev_q   <= line_rx_i;
      rx_err_q    <= err_set || (rx_err_q && !err_clr);
      rx_byte_v_q <= byte_set || (rx_byte_v_q && !rx_take);
      if (byte_set) begin
        rx_byte_q <= {rx_dec, rx_sh_q[7:1]};
      end
      if (clr || !line_rx_active_i) begin
        rx_st_q   <= RX_HUNT;
        rx_pkt_q  <= 1'b0;
        rx_zero_q <= 3'h0;
      end else if (rx_st_q == RX_HUNT) begin
        // Sync pattern is consumed here and never reaches the link
        if (!rx_dec) begin
          rx_zero_q <= (rx_zero_q == SYNC_MIN_ZERO) ? rx_zero_q : rx_zero_q + 3'h1;
        end else if (err_clr) begin
          rx_st_q   <= RX_DATA;
          rx_pkt_q  <= 1'b1;
          rx_cnt_q  <= 3'h0;
          rx_ones_q <= 3'h1;
        end else begin
          rx_zero_q <= 3'h0;
        end
      end else if (line_rx_se0_i || err_set && !byte_set) begin
        rx_st_q   <= RX_HUNT;
        rx_pkt_q  <= 1'b0;
        rx_zero_q <= 3'h0;
      end else if (rx_ones_q == STUFF_RUN) begin
        rx_ones_q <= 3'h0;
      end else begin
        rx_sh_q   <= {rx_dec, rx_sh_q[7:1]};
        rx_cnt_q  <= rx_cnt_q + 3'h1;
        rx_ones_q <= rx_dec ? rx_ones_q + 3'h1 : 3'h0;
      end
    end
  end

  // ****************************************
  // Status byte
  // ****************************************
  logic [7:0] rxcmd, last_rxcmd_q;
  logic [1:0] evt;
  assign evt   = rx_err_q ? EVT_ERROR : (rx_pkt_q ? EVT_ACTIVE : EVT_IDLE);
  always_comb begin
    rxcmd = 8'h00;
    rxcmd[RXC_LS_LSB +: 2]     = {line_rx_se0_i, line_rx_i};
    rxcmd[RXC_IRQ_LSB +: IRQ_W] = pin_q[NSYNC-1:2] & irq_en_i;
    rxcmd[RXC_EVT_LSB +: 2]    = evt;
  end

  // ****************************************
  // Bus controller
  // ****************************************
  ulsd_ctl_state_type st_q, tgt_q;
  logic [7:0] data_q;
  logic       dir_q, nxt_rx_q, cmd_ok, ser_rdy, ser_ld, ser_line, ser_se0, ser_en;
  logic [1:0] kind;

  assign kind    = cmd_kind(ulpi_data_i);
  assign cmd_ok  = (st_q == C_IDLE) && !rx_pkt_q && (ulpi_data_i != 8'h00) &&
                   (kind != 2'h0) && ((kind != CMD_TX) || ser_rdy);
  assign rx_take = (st_q == C_RX) && rx_byte_v_q;
  assign ser_ld  = cmd_ok && (kind == CMD_TX) ||
                   (st_q == C_TX) && ser_rdy && !ulpi_stp_i;
  assign ulpi_nxt_o = cmd_ok || (st_q == C_REGW) || nxt_rx_q ||
                      ((st_q == C_TX) && ser_rdy && !ulpi_stp_i);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q         <= C_IDLE;
      tgt_q        <= C_RX;
      dir_q        <= 1'b0;
      nxt_rx_q     <= 1'b0;
      data_q       <= 8'h00;
      last_rxcmd_q <= 8'h00;
      reg_addr_o   <= '0;
      reg_wdata_o  <= 8'h00;
      reg_we_o     <= 1'b0;
      reg_re_o     <= 1'b0;
    end else if (ce_i) begin
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      nxt_rx_q <= 1'b0;
      if (clr) begin
        st_q  <= C_IDLE;
        dir_q <= 1'b0;
      end else begin
        case (st_q)
          C_IDLE: begin
            if (rx_pkt_q) begin
              dir_q <= 1'b1;
              tgt_q <= C_RX;
              st_q  <= C_TURN_UP;
            end else if (cmd_ok) begin
              reg_addr_o <= ulpi_data_i[ADDR_W-1:0];
              if (kind == CMD_TX) begin
                st_q <= C_TX;
              end else if (kind == CMD_REGW) begin
                st_q <= C_REGW;
              end else begin
                reg_re_o <= 1'b1;
                dir_q    <= 1'b1;
                tgt_q    <= C_RR_DATA;
                st_q     <= C_TURN_UP;
              end
            end else if (rxcmd != last_rxcmd_q) begin
              dir_q <= 1'b1;
              tgt_q <= C_RXCMD;
              st_q  <= C_TURN_UP;
            end
          end
          C_TURN_UP: begin
            data_q <= (tgt_q == C_RR_DATA) ? reg_rdata_i : rxcmd;
            if (tgt_q != C_RR_DATA) begin
              last_rxcmd_q <= rxcmd;
            end
            st_q <= tgt_q;
          end
          C_RX: begin
            if (rx_byte_v_q) begin
              data_q   <= rx_byte_q;
              nxt_rx_q <= 1'b1;
            end else if (rx_pkt_q) begin
              data_q       <= rxcmd;
              last_rxcmd_q <= rxcmd;
            end else begin
              data_q       <= rxcmd;
              last_rxcmd_q <= rxcmd;
              st_q         <= C_RXCMD;
            end
          end
          C_RXCMD, C_RR_DATA: begin
            dir_q <= 1'b0;
            st_q  <= C_TURN_DN;
          end
          C_TURN_DN: st_q <= C_IDLE;
          C_TX: begin
            if (ulpi_stp_i) begin
              st_q <= C_IDLE;
            end
          end
          C_REGW: begin
            reg_wdata_o <= ulpi_data_i;
            reg_we_o    <= 1'b1;
            st_q        <= C_REGW_STP;
          end
          C_REGW_STP: begin
            if (ulpi_stp_i) begin
              st_q <= C_IDLE;
            end
          end
          default: st_q <= C_IDLE;
        endcase
      end
    end
  end

  ulsd_serializer u_ser (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .ce_i        (ce_i),
    .clr_i       (clr),
    .ld_i        (ser_ld),
    .ld_byte_i   ((st_q == C_IDLE) ? {~ulpi_data_i[3:0], ulpi_data_i[3:0]} : ulpi_data_i),
    .ld_framed_i ((st_q == C_IDLE) && (ulpi_data_i[3:0] != 4'h0)),
    .end_i       ((st_q == C_TX) && ulpi_stp_i),
    .rdy_o       (ser_rdy),
    .line_o      (ser_line),
    .se0_o       (ser_se0),
    .en_o        (ser_en)
  );

  // ****************************************
  // Pin muxing and serial modes
  // ****************************************
  // Serial modes bypass the serializer: the link drives line state on the data pins
  always_comb begin
    ulpi_data_o      = data_q;
    ulpi_data_oe_n_o = {8{!(dir_q && st_q != C_TURN_UP)}};
    ulpi_dir_o       = dir_q;
    line_tx_o        = ser_line;
    line_tx_se0_o    = ser_se0;
    line_tx_en_o     = ser_en;
    if (serial) begin
      ulpi_dir_o       = 1'b0;
      line_tx_en_o     = ulpi_data_i[0];
      line_tx_o        = ulpi_data_i[1];
      line_tx_se0_o    = ulpi_data_i[2];
      ulpi_data_o      = {2'h0, line_rx_se0_i, line_rx_i, |rxcmd[RXC_IRQ_LSB +: IRQ_W], 3'h0};
      ulpi_data_oe_n_o = 8'hf7;
      if (serial_mode_i == MODE_SER6) begin
        ulpi_data_oe_n_o = 8'hc7;
      end else if (serial_mode_i == MODE_SER3 && !ulpi_data_i[0]) begin
        ulpi_data_o[2:1] = {line_rx_se0_i, line_rx_i};
        ulpi_data_oe_n_o = 8'hf1;
      end
    end
    if (pin_q[0]) begin
      ulpi_data_oe_n_o = 8'hff;
    end
  end
endmodule : ulsd_ulpi_phy

// *** test/tb.sv ***
// Testbench for the ULPI transceiver core: link model, line stimulus, register file.
// Assumes the checker is bound to the design by its own file.
module tb import ulsd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, arst_n, cs_pd, vio, pd_en, stp, drv, dir, nxt, flt, pdo, rx, rx_se0, rx_act;
  logic       txl, txse0, txen, we, re, regoff, pwd, prevl, eop_seen, err_seen;
  logic [1:0] smode;
  logic [3:0] irq, irq_en;
  logic [5:0] addr;
  logic [7:0] bus, dout, oe_n, link_d, wdata, last_cmd;
  logic [7:0] mem [64];
  logic       cap[$];
  logic [7:0] rxq[$];
  int         fail_count, n_compared;

  // Undriven lines show the pull-down or the inverse of the link's last value
  assign bus = (~oe_n & dout) | (oe_n & (drv ? link_d : (pdo ? 8'h00 : ~link_d)));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ulsd_link_model link_inst (.clk_i(clk), .dir_i(dir), .nxt_i(nxt), .data_o(link_d), .stp_o(stp), .drv_o(drv));
  ulsd_ulpi_phy ulsd_ulpi_phy_inst (
    .sys_clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1), .chip_select_powerdown_n_i(cs_pd),
    .vio_present_i(vio), .serial_mode_i(smode), .bus_pulldown_en_i(pd_en), .ulpi_data_i(bus),
    .ulpi_data_o(dout), .ulpi_data_oe_n_o(oe_n), .ulpi_dir_o(dir), .ulpi_nxt_o(nxt), .ulpi_stp_i(stp),
    .ulpi_float_o(flt), .ulpi_pulldown_o(pdo), .line_rx_i(rx), .line_rx_se0_i(rx_se0),
    .line_rx_active_i(rx_act), .line_tx_o(txl), .line_tx_se0_o(txse0), .line_tx_en_o(txen),
    .irq_src_i(irq), .irq_en_i(irq_en), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_we_o(we),
    .reg_re_o(re), .reg_rdata_i(mem[addr]), .regulator_off_o(regoff), .powerdown_o(pwd));

  // ****
  // Monitors, sampled mid-cycle where every output has settled
  // ****
  always @(negedge clk) begin
    if (we) mem[addr] <= wdata;
    if (txen && !txse0 && !eop_seen) cap.push_back(txl === prevl);
    if (txse0) eop_seen <= 1'b1;
    prevl <= txl;
    if (dir && nxt) rxq.push_back(dout);
    if (dir && !nxt && oe_n === 8'h00) last_cmd <= dout;
    if (dir && !nxt && oe_n === 8'h00 && dout[7:6] === EVT_ERROR) err_seen <= 1'b1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task conclude;
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic ok_or_end(input bit ok, input string msg);
    if (!ok) begin
      chk(8'h00, 8'h01, msg);
      conclude();
    end
  endtask : ok_or_end
  task automatic wait_dir(input logic lvl);
    for (int n = 0; n < 100 && dir !== lvl; n++) cyc(1);
    ok_or_end(dir === lvl, "dir wait");
  endtask : wait_dir

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    arst_n = 1'b0;
    cyc(2);
    chk({dir, flt, regoff, txl, txen}, 8'h0e, "reset outputs");
    chk(oe_n, 8'hff, "reset oe");
    arst_n = 1'b1;
    cyc(6);
  endtask : t_reset
  task automatic t_regs;
    bit ok;
    link_inst.send('{8'h84, 8'h20}, 1, ok);
    ok_or_end(ok, "write");
    link_inst.send('{8'h8a, 8'hc3}, 1, ok);
    ok_or_end(ok, "write");
    chk(mem[6'h04], 8'h20, "write a");
    chk(mem[6'h0a], 8'hc3, "write b");
    link_inst.send('{8'hca}, 0, ok);
    ok_or_end(ok, "read");
    wait_dir(1'b1);
    cyc(1);
    chk(dout, 8'hc3, "read data");
    chk(oe_n, 8'h00, "read oe");
    wait_dir(1'b0);
  endtask : t_regs
  task automatic t_tx;
    bit         ok;
    logic       b[$];
    int         ones;
    logic [7:0] bytes[3] = '{8'h80, 8'hc3, 8'hff};
    ones = 0;
    foreach (bytes[k]) for (int i = 0; i < 8; i++) begin
      b.push_back(bytes[k][i]);
      ones = bytes[k][i] ? ones + 1 : 0;
      if (ones == 6) begin
        b.push_back(1'b0);
        ones = 0;
      end
    end
    cap.delete();
    eop_seen = 1'b0;
    link_inst.send('{8'h43, 8'hff}, 1, ok);
    ok_or_end(ok, "tx send");
    for (int n = 0; n < 200 && !(eop_seen && !txen); n++) cyc(1);
    ok_or_end(eop_seen && !txen, "tx end");
    chk(8'(cap.size()), 8'(b.size()), "tx bits");
    foreach (b[i]) chk({7'h0, cap[i]}, {7'h0, b[i]}, "tx bit");
  endtask : t_tx
  task automatic t_rx(input logic [7:0] bytes[$], input int extra, input bit bad);
    logic lvl;
    logic bits[$];
    lvl = 1'b1;
    rxq.delete();
    err_seen = 1'b0;
    foreach (bytes[k]) for (int i = 0; i < 8; i++) bits.push_back(bytes[k][i]);
    repeat (extra) bits.push_back(1'b1);
    rx_act = 1'b1;
    foreach (bits[i]) begin
      lvl = bits[i] ? lvl : ~lvl;
      rx = lvl;
      cyc(1);
    end
    rx_se0 = 1'b1;
    cyc(2);
    {rx_se0, rx_act, rx} = 3'b001;
    wait_dir(1'b0);
    cyc(2);
    chk({7'h0, err_seen}, {7'h0, bad}, "rx error");
    if (!bad) chk(8'(rxq.size()), 8'h01, "rx count");
    if (!bad) chk(rxq[0], bytes[1], "rx byte");
  endtask : t_rx
  task automatic t_status;
    logic seen;
    // Let trailing line-state updates finish, or a stale one is taken for the irq update
    cyc(10);
    irq_en = 4'h4;
    irq = 4'h5;
    wait_dir(1'b1);
    wait_dir(1'b0);
    chk({4'h0, last_cmd[5:2]}, 8'h04, "irq status");
    chk({6'h0, last_cmd[1:0]}, 8'h01, "line status");
    irq = 4'h7;
    seen = 1'b0;
    repeat (20) begin
      cyc(1);
      seen = seen | dir;
    end
    chk({7'h0, seen}, 8'h00, "masked irq");
  endtask : t_status
  task automatic t_mid_reset;
    bit ok;
    link_inst.send('{8'hca}, 0, ok);
    ok_or_end(ok, "read before reset");
    wait_dir(1'b1);
    arst_n = 1'b0;
    #1;
    chk({7'h0, dir}, 8'h00, "async dir");
    chk(oe_n, 8'hff, "async oe");
    cyc(1);
    arst_n = 1'b1;
    cyc(6);
  endtask : t_mid_reset
  task automatic t_power;
    pd_en = 1'b1;
    cyc(1);
    chk({7'h0, pdo}, 8'h01, "pulldown");
    cs_pd = 1'b1;
    cyc(6);
    chk({flt, regoff, pwd, pdo}, 8'h0e, "powerdown");
    chk(oe_n, 8'hff, "powerdown oe");
    cs_pd = 1'b0;
    cyc(6);
    chk({flt, regoff}, 8'h00, "wake");
    vio = 1'b0;
    cyc(6);
    chk({7'h0, regoff}, 8'h01, "no io supply");
    vio = 1'b1;
    cyc(6);
  endtask : t_power
  task automatic t_serial;
    for (int m = 0; m < 2; m++) begin
      smode = m ? MODE_SER3 : MODE_SER6;
      cyc(4);
      for (int v = 0; v < 2; v++) begin
        rx = v[0];
        cyc(1);
        chk({7'h0, dout[m ? 1 : 4]}, {7'h0, v[0]}, "serial rx line");
      end
    end
    smode = MODE_PAR;
    rx = 1'b1;
    cyc(6);
  endtask : t_serial

  initial begin
    {cs_pd, vio, pd_en, rx, rx_se0, rx_act} = 6'b010100;
    {smode, irq, irq_en} = 10'h000;
    {fail_count, n_compared} = 0;
    {eop_seen, err_seen, prevl} = 3'b001;
    t_reset();
    t_regs();
    t_tx();
    t_rx('{8'h80, 8'h5a}, 0, 1'b0);
    t_rx('{8'h80, 8'hff}, 1, 1'b1);
    t_status();
    t_mid_reset();
    t_power();
    t_serial();
    conclude();
  end
endmodule : tb

// *** test/ulsd_link_model.sv ***
// Link controller model: hands command and data bytes to the transceiver.
// Assumes the bench resolves the shared data bus from every party's enables.
module ulsd_link_model (
  input  wire logic       clk_i,
  input  wire logic       dir_i,
  input  wire logic       nxt_i,
  output logic      [7:0] data_o,
  output logic            stp_o,
  output logic            drv_o
);
  timeunit 1ns;
  timeprecision 100ps;
  assign drv_o = !dir_i;
  initial begin
    data_o = 8'h00;
    stp_o  = 1'b0;
  end
  // Each byte stands until nxt is seen; nxt is looked at before the edge to avoid a race
  task automatic send(input logic [7:0] bytes[$], input bit with_stop, output bit ok);
    bit hit;
    int n;
    ok = 1'b1;
    foreach (bytes[i]) begin
      data_o = bytes[i];
      n = 0;
      do begin
        @(negedge clk_i);
        hit = nxt_i && !dir_i;
        @(posedge clk_i);
        n++;
      end while (!hit && n < 200);
      ok = ok && hit;
      #1;
    end
    data_o = 8'h00;
    if (with_stop) begin
      stp_o = 1'b1;
      @(posedge clk_i);
      #1 stp_o = 1'b0;
    end
  endtask : send
endmodule : ulsd_link_model

// *** test/ulsd_ulpi_phy_checker.sv ***
// Assertion checker for the ULPI transceiver core, bound to its top module.
// Assumes ce_i stays high, so every clock edge is an enabled cycle.
module ulsd_ulpi_phy_checker import ulsd_pkg::*; (
  input wire logic       sys_clk_i,
  input wire logic       arst_n_i,
  input wire logic       chip_select_powerdown_n_i,
  input wire logic [1:0] serial_mode_i,
  input wire logic       bus_pulldown_en_i,
  input wire logic [7:0] ulpi_data_oe_n_o,
  input wire logic       ulpi_dir_o,
  input wire logic       ulpi_nxt_o,
  input wire logic       ulpi_float_o,
  input wire logic       ulpi_pulldown_o,
  input wire logic       line_tx_o,
  input wire logic       line_tx_se0_o,
  input wire logic       line_tx_en_o,
  input wire logic       reg_we_o,
  input wire logic       reg_re_o,
  input wire logic       regulator_off_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Run of decoded ones on the transmit line
  // ****
  logic       prev_line_q;
  logic [3:0] ones_q;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_line_q <= 1'b1;
      ones_q      <= 4'h0;
    end else begin
      prev_line_q <= line_tx_o;
      ones_q      <= (line_tx_en_o && !line_tx_se0_o && line_tx_o == prev_line_q) ? ones_q + 4'h1 : 4'h0;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_stuff_run_limit: assert property (ones_q <= 4'h6)
    else $error("stuff run too long");
  a_float_tristate: assert property (ulpi_float_o |-> ulpi_data_oe_n_o == 8'hff)
    else $error("pins driven while floating");
  a_pin_high_floats: assert property (chip_select_powerdown_n_i [*6] |-> ulpi_float_o)
    else $error("powerdown pin ignored");
  a_regulator_off_float: assert property (ulpi_float_o |-> regulator_off_o)
    else $error("regulator on in powerdown");
  a_pulldown_gate: assert property (ulpi_pulldown_o == (bus_pulldown_en_i && !ulpi_float_o))
    else $error("pulldown state wrong");
  a_dir_turnaround: assert property (serial_mode_i == MODE_PAR && $rose(ulpi_dir_o)
    |-> !ulpi_nxt_o && ulpi_data_oe_n_o == 8'hff ##1 (ulpi_data_oe_n_o == 8'h00 || !ulpi_dir_o))
    else $error("turnaround broken");
  a_link_owns_bus: assert property (serial_mode_i == MODE_PAR && $past(serial_mode_i) == MODE_PAR
    && !ulpi_dir_o |-> ulpi_data_oe_n_o == 8'hff)
    else $error("bus driven without dir");
  a_write_after_data: assert property (reg_we_o |-> $past(ulpi_nxt_o) && $past(ulpi_nxt_o, 2))
    else $error("write without two accepted bytes");
  a_read_in_turn: assert property (reg_re_o |-> $rose(ulpi_dir_o))
    else $error("read outside turnaround");
  a_eop_shape: assert property ($rose(line_tx_se0_o) |-> line_tx_se0_o [*2] ##1 (!line_tx_se0_o && line_tx_o))
    else $error("end pattern malformed");

  cover property (reg_we_o);
  cover property ($rose(line_tx_se0_o));
  cover property (ulpi_dir_o && ulpi_nxt_o);
  cover property (ulpi_float_o);
endmodule : ulsd_ulpi_phy_checker

bind ulsd_ulpi_phy ulsd_ulpi_phy_checker ulsd_ulpi_phy_checker_inst (.*);
